// *** hw/pcr_pkg.sv ***
/*
 * Constants shared by the port pin block: register offsets, field
 * positions, reset values, bus responses and synchroniser depth.
 * Assumes a 32-bit AXI4-Lite register bus and eight port pins.
 */
package pcr_pkg;
   localparam int PCR_PINS = 8;
   localparam int PCR_TIM_CH = 4;
   localparam int PCR_PWM_CH = 6;
   localparam int PCR_ROUTE_W = 4;
   localparam int PCR_AW = 8;
   localparam int PCR_DW = 32;
   localparam int PCR_SYNC_STAGES = 2;

   localparam logic [PCR_AW-1:0] PCR_OFF_DATA = 8'h00;
   localparam logic [PCR_AW-1:0] PCR_OFF_INPUT = 8'h04;
   localparam logic [PCR_AW-1:0] PCR_OFF_DIR = 8'h08;
   localparam logic [PCR_AW-1:0] PCR_OFF_REDUCE = 8'h0c;
   localparam logic [PCR_AW-1:0] PCR_OFF_PULL_EN = 8'h10;
   localparam logic [PCR_AW-1:0] PCR_OFF_PULL_POL = 8'h14;
   localparam logic [PCR_AW-1:0] PCR_OFF_ROUTE = 8'h18;
   localparam logic [PCR_AW-1:0] PCR_OFF_EDGE_EN = 8'h1c;

   localparam logic [PCR_PINS-1:0] PCR_RST_BYTE = 8'h00;
   localparam logic [PCR_ROUTE_W-1:0] PCR_RST_ROUTE = 4'h0;
   localparam int PCR_STRB_LANE = 0;

   localparam logic [1:0] PCR_RESP_OKAY = 2'h0;
   localparam logic [1:0] PCR_RESP_SLVERR = 2'h2;
endpackage

// *** hw/pcr_sync.sv ***
/*
 * Two-stage level synchroniser, one bit per lane.
 * Assumes the inputs are asynchronous pin levels; reset clears both
 * stages, matching the quiet state of an undriven port.
 */
`timescale 1ns/100ps
module pcr_sync #(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   import pcr_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pcr_sync_st_t;

   pcr_sync_st_t st_ff;
   pcr_sync_st_t nxt_st;

   // First stage feeds only the second stage
   always_comb begin
      nxt_st.s1 = async_in;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.s2;
endmodule

// *** hw/pcr_port.sv ***
/*
 * Port pin configuration and routing: direction, output data, input
 * readback, reduced drive, pull control, timer/PWM routing, analog
 * override, and the AXI4-Lite register slave.
 * Assumes timer, PWM and analog enables arrive on core_clk; pin levels
 * are asynchronous and are synchronised here.
 */
// The address map and the AXI4-Lite register port are this design's own decisions.
// Summary of operation
// - Polarity bit 0 selects pull-up, 1 selects pull-down.
// - Polarity matters for an input pin with pull enabled, and with edge enable set.
// - Route bit 0 gives pin to timer, 1 to PWM, if enabled.
// - Route decides only when both enabled; peripherals beat general use.
// - All registers but input writable anytime; irrelevant settings stay stored.
// - Output data drives pin only for a general-purpose output.
// - Data read returns pin when input, stored bit when output.
// - Data readback may lag a direction change by three cycles.
// - Input register is read-only synchronised pin level.
// - Direction 0 input, 1 output; ignored under peripheral control.
// - Enabled analog module disables drivers, forces inputs to 1.
// - Reduce bit selects reduced drive only on output pins.
// - Pull active only on inputs; push-pull outputs have no pull.
// - With edge enable, polarity 0 selects falling, 1 rising.
// - Reset makes every pin a general-purpose input.
// - Reset clears all registers asynchronously.
`timescale 1ns/100ps
module pcr_port (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [pcr_pkg::PCR_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [pcr_pkg::PCR_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [pcr_pkg::PCR_AW-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [pcr_pkg::PCR_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic [pcr_pkg::PCR_TIM_CH-1:0] tim_oc_en,
   input wire logic [pcr_pkg::PCR_TIM_CH-1:0] tim_oc_out,
   input wire logic [pcr_pkg::PCR_PWM_CH-1:0] pwm_ch_en,
   input wire logic [pcr_pkg::PCR_PWM_CH-1:0] pwm_ch_out,
   input wire logic [pcr_pkg::PCR_PINS-1:0] analog_en,
   input wire logic [pcr_pkg::PCR_PINS-1:0] pin_in,
   output logic [pcr_pkg::PCR_PINS-1:0] pin_out,
   output logic [pcr_pkg::PCR_PINS-1:0] pin_oe,
   output logic [pcr_pkg::PCR_PINS-1:0] pin_reduce,
   output logic [pcr_pkg::PCR_PINS-1:0] pin_pull_up_en,
   output logic [pcr_pkg::PCR_PINS-1:0] pin_pull_dn_en,
   output logic [pcr_pkg::PCR_PINS-1:0] pin_in_digital,
   output logic [pcr_pkg::PCR_PINS-1:0] edge_rise_sel,
   output logic [pcr_pkg::PCR_PINS-1:0] edge_fall_sel
);
   import pcr_pkg::*;

   typedef struct packed {
      logic [PCR_PINS-1:0] data;
      logic [PCR_PINS-1:0] dir;
      logic [PCR_PINS-1:0] drive_reduce_bits;
      logic [PCR_PINS-1:0] pull_enable_bits;
      logic [PCR_PINS-1:0] pull_polarity_bits;
      logic [PCR_ROUTE_W-1:0] route;
      logic [PCR_PINS-1:0] edge_interrupt_enable;
      logic aw_held;
      logic [PCR_AW-1:0] aw_addr;
      logic w_held;
      logic [PCR_DW-1:0] w_data;
      logic w_lane;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [PCR_DW-1:0] rdata;
      logic [1:0] rresp;
      logic [PCR_PINS-1:0] p_out;
      logic [PCR_PINS-1:0] p_oe;
      logic [PCR_PINS-1:0] p_reduce;
      logic [PCR_PINS-1:0] p_up;
      logic [PCR_PINS-1:0] p_dn;
      logic [PCR_PINS-1:0] p_in;
      logic [PCR_PINS-1:0] e_rise;
      logic [PCR_PINS-1:0] e_fall;
   } pcr_state_t;

   pcr_state_t st_ff;
   pcr_state_t nxt_st;
   logic [PCR_PINS-1:0] pin_sync;
   logic [PCR_PINS-1:0] tim_en8, tim_out8, pwm_en8, pwm_out8, route8;
   logic [PCR_PINS-1:0] tim_own, pwm_own, periph_own, out_eff, in_lvl;
   logic [PCR_PINS-1:0] drv_val;
   logic [PCR_PINS-1:0] wbyte;
   logic [PCR_PINS-1:0] rd_byte;
   logic rd_hit;
   logic wr_fire;

   // Pin levels cross in from outside, so both stages come first
   pcr_sync #(
      .W(PCR_PINS)
   ) u_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   always_comb begin
      tim_en8 = PCR_PINS'(tim_oc_en);
      tim_out8 = PCR_PINS'(tim_oc_out);
      pwm_en8 = PCR_PINS'(pwm_ch_en);
      pwm_out8 = PCR_PINS'(pwm_ch_out);
      route8 = PCR_PINS'(st_ff.route);
      pwm_own = pwm_en8 & (~tim_en8 | route8);
      tim_own = tim_en8 & (~pwm_en8 | ~route8);
      periph_own = pwm_own | tim_own;
      out_eff = periph_own | st_ff.dir;
      drv_val = (pwm_own & pwm_out8) | (tim_own & tim_out8)
         | (~periph_own & st_ff.data);
      in_lvl = pin_sync | analog_en;
   end

   always_comb begin
      rd_hit = 1'b1;
      rd_byte = '0;
      case (s_axi_araddr)
         PCR_OFF_DATA: begin
            // Lags a direction change by the sync depth plus the registered pad enable
            rd_byte = (st_ff.dir & st_ff.data)
               | (~st_ff.dir & in_lvl);
         end
         PCR_OFF_INPUT: begin
            rd_byte = in_lvl;
         end
         PCR_OFF_DIR: begin
            rd_byte = st_ff.dir;
         end
         PCR_OFF_REDUCE: begin
            rd_byte = st_ff.drive_reduce_bits;
         end
         PCR_OFF_PULL_EN: begin
            rd_byte = st_ff.pull_enable_bits;
         end
         PCR_OFF_PULL_POL: begin
            rd_byte = st_ff.pull_polarity_bits;
         end
         PCR_OFF_ROUTE: begin
            rd_byte = route8;
         end
         PCR_OFF_EDGE_EN: begin
            rd_byte = st_ff.edge_interrupt_enable;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      wbyte = st_ff.w_data[PCR_PINS-1:0];
      wr_fire = 1'b0;
      if (s_axi_awvalid && st_ff.awready) begin
         nxt_st.aw_held = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_ff.wready) begin
         nxt_st.w_held = 1'b1;
         nxt_st.w_data = s_axi_wdata;
         nxt_st.w_lane = s_axi_wstrb[PCR_STRB_LANE];
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      // Writes land any time; the pin logic decides what takes effect
      if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
         wr_fire = 1'b1;
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = PCR_RESP_OKAY;
         case (st_ff.aw_addr)
            PCR_OFF_DATA: begin
               if (st_ff.w_lane) nxt_st.data = wbyte;
            end
            PCR_OFF_INPUT: begin
               nxt_st.bresp = PCR_RESP_OKAY;
            end
            PCR_OFF_DIR: begin
               if (st_ff.w_lane) nxt_st.dir = wbyte;
            end
            PCR_OFF_REDUCE: begin
               if (st_ff.w_lane) nxt_st.drive_reduce_bits = wbyte;
            end
            PCR_OFF_PULL_EN: begin
               if (st_ff.w_lane) nxt_st.pull_enable_bits = wbyte;
            end
            PCR_OFF_PULL_POL: begin
               if (st_ff.w_lane) nxt_st.pull_polarity_bits = wbyte;
            end
            PCR_OFF_ROUTE: begin
               if (st_ff.w_lane) nxt_st.route = wbyte[PCR_ROUTE_W-1:0];
            end
            PCR_OFF_EDGE_EN: begin
               if (st_ff.w_lane) nxt_st.edge_interrupt_enable = wbyte;
            end
            default: begin
               nxt_st.bresp = PCR_RESP_SLVERR;
            end
         endcase
      end
      nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid && !wr_fire;
      nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid && !wr_fire;
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_ff.arready) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = PCR_DW'(rd_byte);
         nxt_st.rresp = rd_hit ? PCR_RESP_OKAY : PCR_RESP_SLVERR;
      end
      nxt_st.arready = !nxt_st.rvalid;
      // Analog use overrides the digital drivers and reduced drive, not the pulls
      nxt_st.p_oe = out_eff & ~analog_en;
      nxt_st.p_out = drv_val & ~analog_en;
      nxt_st.p_reduce = out_eff & ~analog_en & st_ff.drive_reduce_bits;
      nxt_st.p_up = ~out_eff & st_ff.pull_enable_bits
         & ~st_ff.pull_polarity_bits;
      nxt_st.p_dn = ~out_eff & st_ff.pull_enable_bits
         & st_ff.pull_polarity_bits;
      nxt_st.p_in = in_lvl;
      nxt_st.e_rise = st_ff.edge_interrupt_enable
         & st_ff.pull_polarity_bits;
      nxt_st.e_fall = st_ff.edge_interrupt_enable
         & ~st_ff.pull_polarity_bits;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
         st_ff.dir <= PCR_RST_BYTE;
         st_ff.route <= PCR_RST_ROUTE;
         st_ff.awready <= 1'b1;
         st_ff.wready <= 1'b1;
         st_ff.arready <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready = st_ff.wready;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign pin_out = st_ff.p_out;
   assign pin_oe = st_ff.p_oe;
   assign pin_reduce = st_ff.p_reduce;
   assign pin_pull_up_en = st_ff.p_up;
   assign pin_pull_dn_en = st_ff.p_dn;
   assign pin_in_digital = st_ff.p_in;
   assign edge_rise_sel = st_ff.e_rise;
   assign edge_fall_sel = st_ff.e_fall;

   a_pull_polarity: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      ((pin_pull_up_en & $past(st_ff.pull_polarity_bits))
      | (pin_pull_dn_en & ~$past(st_ff.pull_polarity_bits))) == '0)
      else $error("pull device disagrees with polarity");
   a_pull_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
      ((pin_pull_up_en | pin_pull_dn_en) & (pin_oe
      | ~$past(st_ff.pull_enable_bits))) == '0)
      else $error("pull active on output or without enable");
   a_route_pwm: assert property (@(posedge core_clk) disable iff (!rst_b)
      (tim_oc_en[0] && pwm_ch_en[0] && st_ff.route[0] && !analog_en[0])
      |=> pin_oe[0] && (pin_out[0] == $past(pwm_ch_out[0])))
      else $error("route select did not give pin to PWM");
   a_periph_prio: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (tim_oc_en[1] && !pwm_ch_en[1] && !st_ff.dir[1] && !analog_en[1])
      |=> pin_oe[1] && (pin_out[1] == $past(tim_oc_out[1])))
      else $error("timer did not take pin over direction");
   a_gpio_drive: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (st_ff.dir[7] && !analog_en[7]) |=> pin_oe[7]
      && (pin_out[7] == $past(st_ff.data[7])))
      else $error("output data not driven");
   a_analog_off: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      analog_en[2] |=> !pin_oe[2] && pin_in_digital[2])
      else $error("analog pin still digital");
   a_reduce_out: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (pin_reduce & ~pin_oe) == '0)
      else $error("reduced drive on non-output pin");
   a_input_sync: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (pin_in[3] && !analog_en[3])[*3] |=> pin_in_digital[3])
      else $error("input level not seen after sync");
   a_edge_sel: assert property (@(posedge core_clk) disable iff (!rst_b)
      (edge_rise_sel & edge_fall_sel) == '0)
      else $error("both edges selected");
   a_read_resp: assert property (@(posedge core_clk) disable iff (!rst_b)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
      else $error("read answer missing");

   c_write_done: cover property (@(posedge core_clk) disable iff (!rst_b)
      s_axi_bvalid && s_axi_bready);
   c_both_route: cover property (@(posedge core_clk) disable iff (!rst_b)
      tim_oc_en[0] && pwm_ch_en[0]);
   c_pull_down: cover property (@(posedge core_clk) disable iff (!rst_b)
      pin_pull_dn_en != '0);
endmodule

// *** verif/pcr_pad_model.sv ***
/*
 * Pad model for the port pins: design drive, external driver, pulls.
 * Assumes pad outputs from the port block; undriven pads toggle.
 */
`timescale 1ns/100ps
module pcr_pad_model (
   input wire logic core_clk,
   input wire logic [pcr_pkg::PCR_PINS-1:0] pin_out,
   input wire logic [pcr_pkg::PCR_PINS-1:0] pin_oe,
   input wire logic [pcr_pkg::PCR_PINS-1:0] pull_up,
   input wire logic [pcr_pkg::PCR_PINS-1:0] pull_dn,
   input wire logic [pcr_pkg::PCR_PINS-1:0] ext_en,
   input wire logic [pcr_pkg::PCR_PINS-1:0] ext_val,
   output logic [pcr_pkg::PCR_PINS-1:0] pin_level
);
   import pcr_pkg::*;
   // Floating pads change every cycle so no stale value can pass
   logic [PCR_PINS-1:0] float_ff = 8'h5a;
   always @(posedge core_clk) float_ff <= ~float_ff;
   always_comb begin
      for (int i = 0; i < PCR_PINS; i++) begin
         // Strong pad driver beats the weak external source
         if (pin_oe[i]) pin_level[i] = pin_out[i];
         else if (ext_en[i]) pin_level[i] = ext_val[i];
         else if (pull_up[i]) pin_level[i] = 1'b1;
         else if (pull_dn[i]) pin_level[i] = 1'b0;
         else pin_level[i] = float_ff[i];
      end
   end
endmodule

// *** verif/tb.sv ***
/*
 * Self-checking bench for the port block over AXI4-Lite.
 * Assumes the pad model closes the loop from pad outputs to pin_in.
 */
`timescale 1ns/100ps
module tb;
   import pcr_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic aw_v = 1'b0, aw_r, w_v = 1'b0, w_r, b_v, ar_v = 1'b0, ar_r, r_v;
   logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
   logic [31:0] w_d = 32'h0, r_d;
   logic [3:0] w_s = 4'h1, tim_en = 4'h0, tim_o = 4'h0;
   logic [1:0] b_rsp, r_rsp;
   logic [5:0] pwm_en = 6'h00, pwm_o = 6'h00;
   logic [7:0] ana = 8'h00, lvl, p_out, p_oe, p_red, p_up, p_dn, p_dig;
   logic [7:0] e_r, e_f, ext_en = 8'hff, ext_v = 8'h00;
   int fail_count = 0;
   int check_count = 0;
   always #5 core_clk = ~core_clk;
   pcr_port u_pcr_port (.core_clk(core_clk), .rst_b(rst_b),
      .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_awaddr(aw_a),
      .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_wdata(w_d),
      .s_axi_wstrb(w_s), .s_axi_bvalid(b_v), .s_axi_bready(1'b1),
      .s_axi_bresp(b_rsp), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
      .s_axi_araddr(ar_a), .s_axi_rvalid(r_v), .s_axi_rready(1'b1),
      .s_axi_rdata(r_d), .s_axi_rresp(r_rsp), .tim_oc_en(tim_en),
      .tim_oc_out(tim_o), .pwm_ch_en(pwm_en), .pwm_ch_out(pwm_o),
      .analog_en(ana), .pin_in(lvl), .pin_out(p_out), .pin_oe(p_oe),
      .pin_reduce(p_red), .pin_pull_up_en(p_up), .pin_pull_dn_en(p_dn),
      .pin_in_digital(p_dig), .edge_rise_sel(e_r), .edge_fall_sel(e_f));
   pcr_pad_model u_pcr_pad_model (.core_clk(core_clk), .pin_out(p_out),
      .pin_oe(p_oe), .pull_up(p_up), .pull_dn(p_dn), .ext_en(ext_en),
      .ext_val(ext_v), .pin_level(lvl));
   task automatic report_and_stop;
      if (fail_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s,
         input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Bready and rready stay high, so each answer is taken when seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      int n = 0;
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      do begin
         @(posedge core_clk);
         if (aw_v && aw_r) aw_v <= 1'b0;
         if (w_v && w_r) w_v <= 1'b0;
         n++;
      end while (b_v !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         report_and_stop();
      end
      chk("bresp", b_rsp, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
         input logic [1:0] er);
      int n = 0;
      ar_a <= a;
      ar_v <= 1'b1;
      do begin
         @(posedge core_clk);
         if (ar_v && ar_r) ar_v <= 1'b0;
         n++;
      end while (r_v !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         report_and_stop();
      end
      chk("rresp", r_rsp, er);
      chk("rdata", r_d, e);
   endtask
   initial begin
      tick(2);
      rst_b <= 1'b1;
      tick(1);
      chk("oe", p_oe, 0);
      chk("pulls", {p_up, p_dn, p_red}, 0);
      chk("edge", {e_r, e_f}, 0);
      for (int i = 0; i < 8; i++) rd(8'(i * 4), 0, PCR_RESP_OKAY);
      rd(8'h20, 0, PCR_RESP_SLVERR);
      wr(8'h20, 32'hff, PCR_RESP_SLVERR);
      wr(PCR_OFF_ROUTE, 32'hff, PCR_RESP_OKAY);
      rd(PCR_OFF_ROUTE, 32'h0f, PCR_RESP_OKAY);
      wr(PCR_OFF_ROUTE, 32'h00, PCR_RESP_OKAY);
      w_s <= 4'he;
      wr(PCR_OFF_DIR, 32'hff, PCR_RESP_OKAY);
      w_s <= 4'h1;
      rd(PCR_OFF_DIR, 0, PCR_RESP_OKAY);
      // Outputs with a conflicting external source
      ext_v <= 8'h3c;
      wr(PCR_OFF_DIR, 32'hff, PCR_RESP_OKAY);
      wr(PCR_OFF_DATA, 32'ha5, PCR_RESP_OKAY);
      wr(PCR_OFF_REDUCE, 32'hff, PCR_RESP_OKAY);
      wr(PCR_OFF_PULL_EN, 32'hff, PCR_RESP_OKAY);
      wr(PCR_OFF_INPUT, 32'h00, PCR_RESP_OKAY);
      tick(5);
      chk("oe", p_oe, 8'hff);
      chk("out", p_out, 8'ha5);
      chk("reduce", p_red, 8'hff);
      chk("pulls", {p_up, p_dn}, 0);
      rd(PCR_OFF_DATA, 32'ha5, PCR_RESP_OKAY);
      rd(PCR_OFF_INPUT, 32'ha5, PCR_RESP_OKAY);
      rd(PCR_OFF_PULL_EN, 32'hff, PCR_RESP_OKAY);
      // Inputs left to the pulls alone
      wr(PCR_OFF_PULL_POL, 32'h0f, PCR_RESP_OKAY);
      ext_en <= 8'h00;
      wr(PCR_OFF_DIR, 32'h00, PCR_RESP_OKAY);
      tick(5);
      chk("pull up", p_up, 8'hf0);
      chk("pull dn", p_dn, 8'h0f);
      chk("oe", p_oe, 0);
      chk("reduce", p_red, 0);
      rd(PCR_OFF_DATA, 32'hf0, PCR_RESP_OKAY);
      rd(PCR_OFF_INPUT, 32'hf0, PCR_RESP_OKAY);
      ext_en <= 8'hff;
      ext_v <= 8'h96;
      wr(PCR_OFF_PULL_EN, 32'h00, PCR_RESP_OKAY);
      // Analog override on the low pins
      wr(PCR_OFF_DIR, 32'hff, PCR_RESP_OKAY);
      ana <= 8'h0f;
      tick(5);
      chk("pulls", {p_up, p_dn}, 0);
      chk("oe", p_oe, 8'hf0);
      chk("digital in", p_dig, 8'haf);
      ana <= 8'h00;
      wr(PCR_OFF_DIR, 32'h00, PCR_RESP_OKAY);
      // Timer and PWM contend on pins 3:0
      tim_en <= 4'hf;
      tim_o <= 4'h5;
      pwm_en <= 6'h3f;
      pwm_o <= 6'h2a;
      tick(3);
      chk("oe", p_oe, 8'h3f);
      chk("out", p_out & 8'h3f, 8'h25);
      wr(PCR_OFF_ROUTE, 32'h0f, PCR_RESP_OKAY);
      tick(2);
      chk("out", p_out & 8'h3f, 8'h2a);
      // Timer alone on pins 3:0 wins whatever the route says
      pwm_en <= 6'h30;
      tick(3);
      chk("oe", p_oe, 8'h3f);
      chk("out", p_out & 8'h3f, 8'h25);
      tim_en <= 4'h0;
      pwm_en <= 6'h00;
      tick(2);
      chk("oe", p_oe, 0);
      wr(PCR_OFF_EDGE_EN, 32'hff, PCR_RESP_OKAY);
      tick(2);
      chk("rise", e_r, 8'h0f);
      chk("fall", e_f, 8'hf0);
      // Reset taken between clock edges
      rst_b <= 1'b0;
      #2;
      chk("rise", e_r, 0);
      tick(2);
      rst_b <= 1'b1;
      tick(1);
      rd(PCR_OFF_EDGE_EN, 0, PCR_RESP_OKAY);
      rd(PCR_OFF_ROUTE, 0, PCR_RESP_OKAY);
      report_and_stop();
   end
endmodule
